// *** core/cmr_pkg.sv ***
// shared constants, types and helpers of the converter register bank
package cmr_pkg;

	// register addresses as seen by the serial master
	localparam logic [15:0] ADR_CUR_LOW = 16'h000F;
	localparam logic [15:0] ADR_STATION = 16'h0010;
	localparam logic [15:0] ADR_BAUD = 16'h0012;
	localparam logic [15:0] ADR_KIND = 16'h0013;
	localparam logic [15:0] ADR_FW = 16'h0014;
	localparam logic [15:0] ADR_UID = 16'h0015;
	localparam logic [15:0] ADR_CAL_VAL = 16'h001A;
	localparam logic [15:0] ADR_PROBE_RAW = 16'h001B;
	localparam logic [15:0] ADR_RESIST = 16'h001C;
	localparam logic [15:0] ADR_TEMP = 16'h001D;
	localparam logic [15:0] ADR_CUR_RAW = 16'h001E;
	localparam logic [15:0] ADR_CUR_VAL = 16'h001F;
	localparam logic [15:0] ADR_OUT_CUR = 16'h0020;
	localparam logic [15:0] ADR_FLAGS = 16'h0021;
	localparam logic [15:0] ADR_CAL_CMD = 16'h0022;
	localparam logic [15:0] ADR_A1_FUNC = 16'h0023;
	localparam logic [15:0] ADR_A1_SENSE = 16'h0024;
	localparam logic [15:0] ADR_A1_THA = 16'h0025;
	localparam logic [15:0] ADR_A1_THB = 16'h0026;
	localparam logic [15:0] ADR_A1_HYST = 16'h0027;
	localparam logic [15:0] ADR_MAP_LAST = 16'h002C;
	localparam logic [15:0] ADR_RESULT = 16'h00C8;

	// serial function codes and exception answers
	localparam logic [7:0] FC_READ = 8'h03;
	localparam logic [7:0] FC_WRITE1 = 8'h06;
	localparam logic [7:0] FC_WRITEN = 8'h10;
	localparam logic [7:0] EXC_NONE = 8'h00;
	localparam logic [7:0] EXC_FUNC = 8'h01;
	localparam logic [7:0] EXC_ADDR = 8'h02;
	localparam logic [7:0] EXC_VALUE = 8'h03;

	// accepted ranges; thresholds are signed tenths of a degree
	localparam logic [15:0] STATION_MAX = 16'h00F7;
	localparam logic [15:0] BAUD_MAX = 16'h0007;
	localparam logic [15:0] FUNC_MAX = 16'h0005;
	localparam logic [15:0] SENSE_MAX = 16'h0001;
	localparam logic signed [15:0] THR_MIN = 16'shF831;
	localparam logic signed [15:0] THR_MAX = 16'sh270F;
	localparam logic [15:0] HYST_MAX = 16'h270F;
	localparam int TEMP_SCALE = 10;
	localparam int CUR_SCALE = 100000;

	// status word bit positions
	localparam int FLG_SHORT = 0;
	localparam int FLG_OPEN = 1;
	localparam int FLG_CUR_LOW = 4;
	localparam int FLG_CUR_HIGH = 5;
	localparam int FLG_NV_BAD = 9;
	localparam int FLG_TEMP_FAIL = 10;
	localparam int FLG_ALM1 = 12;
	localparam int FLG_ALM2 = 13;
	localparam logic [15:0] FLG_USED = 16'h3633;

	// reset values
	localparam logic [15:0] RST_STATION = 16'h0001;
	localparam logic [15:0] RST_BAUD = 16'h0003;
	localparam logic [16:0] RST_BAUD_RATE = 17'h02580;
	localparam logic [15:0] RST_ZERO = 16'h0000;

	typedef enum logic [2:0] {ALM_OFF, ALM_ABS_HIGH, ALM_ABS_LOW, ALM_DEVIATION, ALM_BAND, ALM_ONOFF} cmr_alarm_fn_e;

	typedef struct packed {
		logic valid;
		logic [7:0] func;
		logic [15:0] addr;
		logic [15:0] wdata;
	} cmr_req_s;

	typedef struct packed {
		logic valid;
		logic [7:0] exc;
		logic [15:0] rdata;
	} cmr_rsp_s;

	typedef struct packed {
		logic [15:0] probe_raw;
		logic [15:0] resistance;
		logic [15:0] temperature;
		logic [15:0] cur_raw;
		logic [15:0] cur_val;
		logic [15:0] out_cur;
		logic [15:0] cur_high_limit;
		logic temp_mode;
		logic probe_short;
		logic probe_open;
		logic cur_low;
		logic cur_high;
		logic nv_bad;
		logic temp_fail;
		logic alarm2_active;
	} cmr_meas_s;

	function automatic logic [16:0] cmr_baud_of(input logic [2:0] code);
		case (code)
			3'h0: cmr_baud_of = 17'h004B0;
			3'h1: cmr_baud_of = 17'h012C0;
			3'h2: cmr_baud_of = 17'h012C0;
			3'h3: cmr_baud_of = 17'h02580;
			3'h4: cmr_baud_of = 17'h04B00;
			3'h5: cmr_baud_of = 17'h09600;
			3'h6: cmr_baud_of = 17'h0E100;
			default: cmr_baud_of = 17'h1C200;
		endcase
	endfunction

endpackage

// *** core/cmr_regbank.sv ***
// parameter and measurement register bank with the first alarm output
// What this block does
// - refuse input low limit above upper limit
// - station address accepted only 0 to 247
// - new station address used after restart only
// - baud code maps to fixed rate table
// - new baud code applied after restart only
// - probe raw, resistance, temperature read-only
// - current raw count and value read-only
// - analog output current read-only
// - status bits 0,1 probe short/open
// - status bits 4,5 current under/over range
// - status bits 9,10 bad parameters, temperature failure
// - status bits 12,13 alarm one/two active
// - writable volatile calibration value register
// - alarm function code selects six behaviours
// - polarity bit selects NC or NO contact
// - threshold one trip/lower limit, -1999..9999
// - threshold two upper limit for 3,4
// - hysteresis 0..9999 governs alarm release
// - only functions 03, 06, 10 accepted
// - writes to read-only registers ignored
// - temperatures signed tenths of a degree
// - currents scaled relative to milliamperes
module cmr_regbank #(
	parameter logic [15:0] KIND_CODE = 16'h00A5, // arbitrary value
	parameter logic [15:0] FW_CODE = 16'h0042, // arbitrary value
	parameter logic [15:0] UID_CODE = 16'h1234 // arbitrary value
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_restart,
	input wire cmr_pkg::cmr_req_s i_req,
	input wire cmr_pkg::cmr_meas_s i_meas,
	output cmr_pkg::cmr_rsp_s o_rsp,
	output logic [15:0] o_station_addr,
	output logic [16:0] o_baud_rate,
	output logic [15:0] o_status,
	output logic o_alarm1_active,
	output logic o_alarm1_contact,
	output logic [15:0] o_cal_value,
	output logic [15:0] o_cal_cmd,
	output logic o_cal_cmd_wr
);
	import cmr_pkg::*;

	typedef struct packed {
		logic [15:0] cur_low;
		logic [15:0] station;
		logic [15:0] baud;
		logic [15:0] cal_val;
		logic [15:0] cal_cmd;
		logic [15:0] a1_func;
		logic [15:0] a1_sense;
		logic [15:0] a1_tha;
		logic [15:0] a1_thb;
		logic [15:0] a1_hyst;
		logic [15:0] act_station;
		logic [16:0] baud_rate;
		logic [15:0] flags;
		logic alarm;
		logic cal_cmd_wr;
		logic contact;
		cmr_rsp_s rsp;
	} cmr_state_s;

	cmr_state_s st;
	cmr_state_s next_st;
	logic [15:0] reg_rd;
	logic [15:0] status_now;
	logic is_wr;
	logic [7:0] exc;
	logic [15:0] rd;
	logic signed [17:0] t;
	logic signed [17:0] tha;
	logic signed [17:0] thb;
	logic signed [17:0] hy;
	logic alarm_next;

	assign is_wr = (i_req.func == FC_WRITE1) || (i_req.func == FC_WRITEN);

	// status word assembled from the measurement side and the alarm one state; unused bits stay zero
	always_comb
	begin
		status_now = 16'h0000;
		status_now[FLG_SHORT] = i_meas.probe_short;
		status_now[FLG_OPEN] = i_meas.probe_open;
		status_now[FLG_CUR_LOW] = i_meas.cur_low;
		status_now[FLG_CUR_HIGH] = i_meas.cur_high;
		status_now[FLG_NV_BAD] = i_meas.nv_bad;
		status_now[FLG_TEMP_FAIL] = i_meas.temp_fail;
		status_now[FLG_ALM1] = st.alarm;
		status_now[FLG_ALM2] = i_meas.alarm2_active;
	end

	// read decode; holes in the map read as zero
	always_comb
	begin
		reg_rd = 16'h0000;
		if (i_req.addr == ADR_CUR_LOW)
			reg_rd = st.cur_low;
		else if (i_req.addr == ADR_STATION)
			reg_rd = st.station;
		else if (i_req.addr == ADR_BAUD)
			reg_rd = st.baud;
		else if (i_req.addr == ADR_KIND)
			reg_rd = KIND_CODE;
		else if (i_req.addr == ADR_FW)
			reg_rd = FW_CODE;
		else if (i_req.addr == ADR_UID)
			reg_rd = UID_CODE;
		else if (i_req.addr == ADR_CAL_VAL)
			reg_rd = st.cal_val;
		else if (i_req.addr == ADR_PROBE_RAW)
			reg_rd = i_meas.probe_raw;
		else if (i_req.addr == ADR_RESIST)
			reg_rd = i_meas.resistance;
		else if (i_req.addr == ADR_TEMP)
			reg_rd = i_meas.temperature;
		else if (i_req.addr == ADR_CUR_RAW)
			reg_rd = i_meas.cur_raw;
		else if (i_req.addr == ADR_CUR_VAL)
			reg_rd = i_meas.cur_val;
		else if (i_req.addr == ADR_OUT_CUR)
			reg_rd = i_meas.out_cur;
		else if (i_req.addr == ADR_FLAGS)
			reg_rd = st.flags;
		else if (i_req.addr == ADR_CAL_CMD)
			reg_rd = st.cal_cmd;
		else if (i_req.addr == ADR_A1_FUNC)
			reg_rd = st.a1_func;
		else if (i_req.addr == ADR_A1_SENSE)
			reg_rd = st.a1_sense;
		else if (i_req.addr == ADR_A1_THA)
			reg_rd = st.a1_tha;
		else if (i_req.addr == ADR_A1_THB)
			reg_rd = st.a1_thb;
		else if (i_req.addr == ADR_A1_HYST)
			reg_rd = st.a1_hyst;
	end

	// alarm decision on sign-extended tenths of a degree
	always_comb
	begin
		t = 18'($signed(i_meas.temperature));
		tha = 18'($signed(st.a1_tha));
		thb = 18'($signed(st.a1_thb));
		hy = 18'($signed(st.a1_hyst));
		alarm_next = st.alarm;
		case (cmr_alarm_fn_e'(st.a1_func[2:0]))
			ALM_ABS_HIGH:
				if (t > tha)
					alarm_next = 1'b1;
				else if (t < tha - hy)
					alarm_next = 1'b0;
			ALM_ABS_LOW:
				if (t < tha)
					alarm_next = 1'b1;
				else if (t > tha + hy)
					alarm_next = 1'b0;
			ALM_DEVIATION:
				if (t > thb || t < tha)
					alarm_next = 1'b1;
				else if (t < thb - hy && t > tha + hy)
					alarm_next = 1'b0;
			ALM_BAND:
				if (t > tha && t < thb)
					alarm_next = 1'b1;
				else if (t > thb + hy || t < tha - hy)
					alarm_next = 1'b0;
			ALM_ONOFF:
				if (t < tha - hy)
					alarm_next = 1'b1;
				else if (t >= tha + hy)
					alarm_next = 1'b0;
			default:
				alarm_next = 1'b0;
		endcase
		// alarms only work while measuring temperature
		if (!i_meas.temp_mode || st.a1_func > FUNC_MAX)
			alarm_next = 1'b0;
	end

	always_comb
	begin
		next_st = st;
		exc = EXC_NONE;
		rd = 16'h0000;
		next_st.rsp.valid = 1'b0;
		next_st.cal_cmd_wr = 1'b0;
		next_st.flags = status_now;
		next_st.alarm = alarm_next;
		if (i_req.valid)
		begin
			next_st.rsp.valid = 1'b1;
			if (i_req.func == FC_READ)
			begin
				if (i_req.addr == ADR_RESULT)
					rd = i_meas.temp_mode ? i_meas.temperature : i_meas.cur_val;
				else if (i_req.addr > ADR_MAP_LAST)
					exc = EXC_ADDR;
				else
					rd = reg_rd;
			end
			else if (is_wr)
			begin
				if (i_req.addr > ADR_MAP_LAST)
					exc = EXC_ADDR;
				else if (i_req.addr == ADR_CUR_LOW)
				begin
					if (i_req.wdata > i_meas.cur_high_limit)
						exc = EXC_VALUE;
					else
						next_st.cur_low = i_req.wdata;
				end
				else if (i_req.addr == ADR_STATION)
				begin
					if (i_req.wdata > STATION_MAX)
						exc = EXC_VALUE;
					else
						next_st.station = i_req.wdata;
				end
				else if (i_req.addr == ADR_BAUD)
				begin
					if (i_req.wdata > BAUD_MAX)
						exc = EXC_VALUE;
					else
						next_st.baud = i_req.wdata;
				end
				else if (i_req.addr == ADR_CAL_VAL)
					next_st.cal_val = i_req.wdata;
				else if (i_req.addr == ADR_CAL_CMD)
				begin
					next_st.cal_cmd = i_req.wdata;
					next_st.cal_cmd_wr = 1'b1;
				end
				else if (i_req.addr == ADR_A1_FUNC)
				begin
					if (i_req.wdata > FUNC_MAX)
						exc = EXC_VALUE;
					else
						next_st.a1_func = i_req.wdata;
				end
				else if (i_req.addr == ADR_A1_SENSE)
				begin
					if (i_req.wdata > SENSE_MAX)
						exc = EXC_VALUE;
					else
						next_st.a1_sense = i_req.wdata;
				end
				else if (i_req.addr == ADR_A1_THA || i_req.addr == ADR_A1_THB)
				begin
					if ($signed(i_req.wdata) < THR_MIN || $signed(i_req.wdata) > THR_MAX)
						exc = EXC_VALUE;
					else if (i_req.addr == ADR_A1_THA)
						next_st.a1_tha = i_req.wdata;
					else
						next_st.a1_thb = i_req.wdata;
				end
				else if (i_req.addr == ADR_A1_HYST)
				begin
					if (i_req.wdata > HYST_MAX)
						exc = EXC_VALUE;
					else
						next_st.a1_hyst = i_req.wdata;
				end
				// other addresses are read-only or unused: no change
			end
			else
				exc = EXC_FUNC;
			next_st.rsp.exc = exc;
			next_st.rsp.rdata = rd;
		end
		// a device restart takes over pending link settings
		if (i_restart)
		begin
			next_st.act_station = st.station;
			next_st.baud_rate = cmr_baud_of(st.baud[2:0]);
		end
		// relay drive built from the sense and alarm values that register with it
		next_st.contact = next_st.a1_sense[0] ? next_st.alarm : ~next_st.alarm;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			st.cur_low <= RST_ZERO;
			st.station <= RST_STATION;
			st.baud <= RST_BAUD;
			st.cal_val <= RST_ZERO;
			st.cal_cmd <= RST_ZERO;
			st.a1_func <= RST_ZERO;
			st.a1_sense <= RST_ZERO;
			st.a1_tha <= RST_ZERO;
			st.a1_thb <= RST_ZERO;
			st.a1_hyst <= RST_ZERO;
			st.act_station <= RST_STATION;
			st.baud_rate <= RST_BAUD_RATE;
			st.flags <= RST_ZERO;
			st.alarm <= 1'b0;
			st.cal_cmd_wr <= 1'b0;
			st.contact <= 1'b1;
			st.rsp <= '0;
		end
		else if (i_ce)
			st <= next_st;
	end

	assign o_rsp = st.rsp;
	assign o_station_addr = st.act_station;
	assign o_baud_rate = st.baud_rate;
	assign o_status = st.flags;
	assign o_alarm1_active = st.alarm;
	assign o_cal_value = st.cal_val;
	assign o_cal_cmd = st.cal_cmd;
	assign o_cal_cmd_wr = st.cal_cmd_wr;
	// NO contact closes while active, NC contact opens while active
	assign o_alarm1_contact = st.contact;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	sequence s_wr_to(logic [15:0] a);
		i_ce && i_req.valid && is_wr && i_req.addr == a;
	endsequence

	sequence s_wr_ro;
		i_ce && i_req.valid && is_wr && (i_req.addr == ADR_FLAGS || i_req.addr == ADR_TEMP || i_req.addr == ADR_KIND);
	endsequence

	chk_low_limit_refuse: assert property (s_wr_to(ADR_CUR_LOW) ##0 (i_req.wdata > i_meas.cur_high_limit) |=>
		o_rsp.exc == EXC_VALUE && $stable(st.cur_low))
		else $error("input low limit accepted above upper limit");
	chk_station_range: assert property (s_wr_to(ADR_STATION) ##0 (i_req.wdata > STATION_MAX) |=>
		$stable(st.station) && o_rsp.exc == EXC_VALUE)
		else $error("station address out of range accepted");
	chk_station_defer: assert property ($changed(o_station_addr) |-> $past(i_restart && i_ce))
		else $error("station address changed without restart");
	chk_baud_defer: assert property ($changed(o_baud_rate) |-> $past(i_restart && i_ce))
		else $error("baud rate changed without restart");
	chk_baud_map: assert property (i_ce && i_restart && st.baud == 16'h0007 |=> o_baud_rate == 17'h1C200)
		else $error("baud code 7 not mapped to top rate");
	chk_ro_ignored: assert property (s_wr_ro |=> $stable(st.cur_low) && $stable(st.a1_func) && $stable(st.cal_cmd)
		&& o_rsp.exc == EXC_NONE)
		else $error("write to read-only register had effect");
	chk_bad_func: assert property (i_ce && i_req.valid && i_req.func != FC_READ && !is_wr |=>
		o_rsp.valid && o_rsp.exc == EXC_FUNC)
		else $error("unsupported function not refused");
	chk_status_zero: assert property ((o_status & ~FLG_USED) == 16'h0000)
		else $error("undefined status bit set");
	chk_status_alarm: assert property (i_ce ##1 1'b1 |-> o_status[FLG_ALM1] == $past(st.alarm))
		else $error("status alarm bit disagrees with alarm");
	chk_alarm_off: assert property ((i_ce && st.a1_func == RST_ZERO) [*2] |-> !o_alarm1_active)
		else $error("alarm active while function is off");
	chk_contact_sense: assert property (o_alarm1_contact == (o_alarm1_active == st.a1_sense[0]))
		else $error("contact sense wrong");
	chk_hyst_range: assert property (s_wr_to(ADR_A1_HYST) ##0 (i_req.wdata > HYST_MAX) |=> $stable(st.a1_hyst))
		else $error("hysteresis above range accepted");
	chk_thr_range: assert property (s_wr_to(ADR_A1_THA) ##0 ($signed(i_req.wdata) < THR_MIN) |=>
		$stable(st.a1_tha))
		else $error("threshold below range accepted");
	chk_abs_high: assert property (i_ce && i_meas.temp_mode && st.a1_func == 16'h0001
		&& $signed(i_meas.temperature) > $signed(st.a1_tha) |=> o_alarm1_active)
		else $error("absolute high alarm did not trip");
	chk_cal_pulse: assert property (s_wr_to(ADR_CAL_CMD) |=>
		o_cal_cmd_wr && o_cal_cmd == $past(i_req.wdata))
		else $error("calibration command write not passed on");
	chk_ce_freeze: assert property (!i_ce |=> $stable(o_alarm1_active) && $stable(o_status) && $stable(o_rsp))
		else $error("state moved while clock enable low");

endmodule

// *** verif/cmr_master.sv ***
// register-port master model standing in for the serial frame decoder
module cmr_master
	import cmr_pkg::*;
(
	input wire logic i_clk,
	output cmr_pkg::cmr_req_s o_req,
	input wire cmr_pkg::cmr_rsp_s i_rsp
);
	timeunit 1ns;
	timeprecision 1ps;

	initial o_req = '0;

	// one register per transfer; caller enters just after a rising edge
	task automatic xfer(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] wd,
		output logic [15:0] rd, output logic [7:0] ex);
		int n;
		n = 0;
		// an edge passes first, so a release and a new request never share a time step
		@(posedge i_clk);
		#1;
		o_req = {1'b1, fc, a, wd};
		@(posedge i_clk);
		#1;
		// released fields never keep their last value
		o_req = {1'b0, ~fc, ~a, ~wd};
		while (i_rsp.valid !== 1'b1 && n < 4)
		begin
			@(posedge i_clk);
			#1;
			n++;
		end
		rd = i_rsp.rdata;
		ex = (n == 4) ? 8'hFF : i_rsp.exc;
	endtask
endmodule

// *** verif/converter_modbus_register_map_bench.sv ***
// self-checking bench of the converter register bank
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; $display("wrong value at %0t: %h %h", $time, (a), (b)); end end
module converter_modbus_register_map_bench
	import cmr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// identity values are arbitrary
	localparam logic [15:0] KIND = 16'h0C3E;
	localparam logic [15:0] FW = 16'h0007;
	localparam logic [15:0] UID = 16'h5A5A;

	logic i_clk, i_rst_n, i_ce, i_restart, alm, contact, cal_wr, m_alm;
	cmr_req_s req;
	cmr_rsp_s rsp;
	cmr_meas_s meas;
	logic [15:0] station, status, cal_val, cal_cmd, rd, m_station;
	logic [16:0] baud, m_baud;
	logic [7:0] ex;
	logic [127:0] rnd;
	logic [15:0] mem [0:44];
	int mismatches, checks_done, cycles, seed;
	logic [15:0] wa [0:16] = '{ADR_CUR_LOW, ADR_CUR_LOW, ADR_STATION, ADR_STATION, ADR_STATION, ADR_BAUD, ADR_BAUD,
		ADR_A1_FUNC, ADR_A1_SENSE, ADR_A1_THA, ADR_A1_THA, ADR_A1_THB, ADR_A1_THB, ADR_A1_HYST, ADR_A1_HYST, ADR_TEMP, ADR_FLAGS};
	logic [15:0] wv [0:16] = '{16'h1001, 16'h1000, 16'h00F8, 16'h00F7, 16'h0005, 16'h0008, 16'h0007, 16'h0006,
		16'h0002, 16'hF830, 16'hF831, 16'h2710, 16'h270F, 16'h2710, 16'h270F, 16'h1234, 16'hFFFF};
	logic [15:0] tl [0:9] = '{16'h00C8, 16'h005A, 16'h0046, 16'h006E, 16'h00FA, 16'h0136, 16'h014A, 16'h0122,
		16'h0032, 16'hFF38};

	cmr_master m (.i_clk(i_clk), .o_req(req), .i_rsp(rsp));

	cmr_regbank #(.KIND_CODE(KIND), .FW_CODE(FW), .UID_CODE(UID)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_ce(i_ce), .i_restart(i_restart), .i_req(req), .i_meas(meas), .o_rsp(rsp), .o_station_addr(station),
		.o_baud_rate(baud), .o_status(status), .o_alarm1_active(alm), .o_alarm1_contact(contact),
		.o_cal_value(cal_val), .o_cal_cmd(cal_cmd), .o_cal_cmd_wr(cal_wr));

	initial
	begin
		i_clk = 0;
		forever #20 i_clk = ~i_clk;
	end

	always @(posedge i_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			conclude();
		end
	end

	function automatic logic [16:0] xb(input logic [15:0] c);
		case (c)
			0: return 17'h004B0;
			1, 2: return 17'h012C0;
			3: return 17'h02580;
			4: return 17'h04B00;
			5: return 17'h09600;
			6: return 17'h0E100;
			default: return 17'h1C200;
		endcase
	endfunction

	function automatic logic [15:0] xs();
		return {2'b00, meas.alarm2_active, m_alm, 1'b0, meas.temp_fail, meas.nv_bad, 3'b000, meas.cur_high,
			meas.cur_low, 2'b00, meas.probe_open, meas.probe_short};
	endfunction

	function automatic logic [15:0] xr(input logic [15:0] a);
		if (a == ADR_RESULT)
			return meas.temp_mode ? meas.temperature : meas.cur_val;
		case (a)
			ADR_PROBE_RAW: return meas.probe_raw;
			ADR_RESIST: return meas.resistance;
			ADR_TEMP: return meas.temperature;
			ADR_CUR_RAW: return meas.cur_raw;
			ADR_CUR_VAL: return meas.cur_val;
			ADR_OUT_CUR: return meas.out_cur;
			ADR_FLAGS: return xs();
			default: return mem[a];
		endcase
	endfunction

	// exception of a write; an accepted write to a writable register lands in the model map
	function automatic logic [7:0] xw(input logic [15:0] a, input logic [15:0] v);
		logic bad;
		bad = 0;
		if (a > ADR_MAP_LAST)
			return EXC_ADDR;
		case (a)
			ADR_CUR_LOW: bad = v > meas.cur_high_limit;
			ADR_STATION: bad = v > 16'd247;
			ADR_BAUD: bad = v > 16'd7;
			ADR_A1_FUNC: bad = v > 16'd5;
			ADR_A1_SENSE: bad = v > 16'd1;
			ADR_A1_THA, ADR_A1_THB: bad = $signed(v) < -1999 || $signed(v) > 9999;
			ADR_A1_HYST: bad = v > 16'd9999;
			ADR_CAL_VAL, ADR_CAL_CMD: bad = 0;
			default: return EXC_NONE;
		endcase
		if (bad)
			return EXC_VALUE;
		mem[a] = v;
		return EXC_NONE;
	endfunction

	function automatic logic xa(input int t, input logic c);
		int v1, v2, h;
		v1 = $signed(mem[ADR_A1_THA]);
		v2 = $signed(mem[ADR_A1_THB]);
		h = mem[ADR_A1_HYST];
		case (mem[ADR_A1_FUNC])
			1: return t > v1 ? 1'b1 : t < v1 - h ? 1'b0 : c;
			2: return t < v1 ? 1'b1 : t > v1 + h ? 1'b0 : c;
			3: return (t > v2 || t < v1) ? 1'b1 : (t > v1 + h && t < v2 - h) ? 1'b0 : c;
			4: return (t > v1 && t < v2) ? 1'b1 : (t > v2 + h || t < v1 - h) ? 1'b0 : c;
			5: return t < v1 - h ? 1'b1 : t >= v1 + h ? 1'b0 : c;
			default: return 1'b0;
		endcase
	endfunction

	task automatic op(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] v);
		logic [7:0] ee;
		logic [15:0] er;
		er = 16'h0000;
		if (fc == FC_READ)
			ee = (a > ADR_MAP_LAST && a != ADR_RESULT) ? EXC_ADDR : EXC_NONE;
		else if (fc == FC_WRITE1 || fc == FC_WRITEN)
			ee = (a == ADR_RESULT) ? EXC_ADDR : xw(a, v);
		else
			ee = EXC_FUNC;
		if (fc == FC_READ && ee == EXC_NONE)
			er = xr(a);
		m.xfer(fc, a, v, rd, ex);
		`CHK(ex, ee)
		`CHK(rd, er)
		`CHK(station, m_station)
		`CHK(baud, m_baud)
		`CHK(cal_val, mem[ADR_CAL_VAL])
		if (fc != FC_READ && a == ADR_CAL_CMD && ee == EXC_NONE)
			`CHK({cal_wr, cal_cmd}, {1'b1, v})
	endtask

	task automatic restart();
		i_restart = 1;
		m_station = mem[ADR_STATION];
		m_baud = xb(mem[ADR_BAUD]);
		@(posedge i_clk);
		#1;
		i_restart = 0;
		`CHK(station, m_station)
		`CHK(baud, m_baud)
	endtask

	task automatic temp_step(input logic [15:0] t);
		meas.temperature = t;
		m_alm = meas.temp_mode ? xa($signed(t), m_alm) : 1'b0;
		repeat (3) @(posedge i_clk);
		#1;
		`CHK(alm, m_alm)
		`CHK(contact, mem[ADR_A1_SENSE][0] ? m_alm : !m_alm)
		`CHK(status, xs())
	endtask

	task automatic do_reset();
		i_rst_n = 0;
		repeat (16) @(posedge i_clk);
		#1;
		i_rst_n = 1;
		foreach (mem[i]) mem[i] = 16'h0000;
		mem[ADR_KIND] = KIND;
		mem[ADR_FW] = FW;
		mem[ADR_UID] = UID;
		mem[ADR_STATION] = 16'h0001;
		mem[ADR_BAUD] = 16'h0003;
		m_station = 16'h0001;
		m_baud = 17'h02580;
		m_alm = 0;
		`CHK({station, baud}, {m_station, m_baud})
	endtask

	task automatic conclude();
		if (mismatches == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		seed = 56;
		i_ce = 1;
		i_restart = 0;
		meas = '0;
		do_reset();
		for (int k = 0; k < 4; k++)
		begin
			rnd = {$random(seed), $random(seed), $random(seed), $random(seed)};
			meas = cmr_meas_s'(rnd[119:0]);
			meas.cur_high_limit = 16'h1000;
			repeat (2) @(posedge i_clk);
			#1;
			for (int a = 0; a <= 16'h2C; a++)
				op(FC_READ, 16'(a), 16'h0000);
			op(FC_READ, ADR_RESULT, 16'h0000);
		end
		op(8'h04, ADR_TEMP, 16'h0000);
		op(FC_READ, 16'h002D, 16'h0000);
		op(FC_WRITE1, ADR_RESULT, 16'h0001);
		for (int i = 0; i < 17; i++)
		begin
			op(i[0] ? FC_WRITEN : FC_WRITE1, wa[i], wv[i]);
			op(FC_READ, wa[i], 16'h0000);
		end
		op(FC_WRITEN, ADR_CAL_VAL, 16'($random(seed)));
		op(FC_WRITE1, ADR_CAL_CMD, 16'($random(seed)));
		op(FC_READ, ADR_CAL_VAL, 16'h0000);
		restart();
		for (int c = 0; c < 8; c++)
		begin
			op(FC_WRITE1, ADR_BAUD, 16'(c));
			restart();
		end
		for (int f = 1; f < 6; f++)
		begin
			meas.temp_mode = 0;
			temp_step(16'h00C8);
			op(FC_WRITE1, ADR_A1_FUNC, 16'(f));
			op(FC_WRITE1, ADR_A1_SENSE, 16'(f % 2));
			op(FC_WRITEN, ADR_A1_THA, 16'h0064);
			op(FC_WRITEN, ADR_A1_THB, 16'h012C);
			op(FC_WRITE1, ADR_A1_HYST, 16'h0014);
			meas.temp_mode = 1;
			foreach (tl[j]) temp_step(tl[j]);
		end
		// clock enable low freezes alarm and status while the temperature moves
		i_ce = 0;
		meas.temperature = 16'h0190;
		repeat (3) @(posedge i_clk);
		#1;
		`CHK({alm, status}, {m_alm, xs()})
		i_ce = 1;
		temp_step(16'h0190);
		do_reset();
		op(FC_READ, ADR_STATION, 16'h0000);
		conclude();
	end
endmodule
